//--- core/fcs_host.sv
// Functional notes
// [R1] address latched at later falling strobe
// [R2] data latched at earlier rising strobe
// [R3] sector chosen by five upper address bits
// [R4] unlock cycles ignore high address, data
// [R5] array read is one plain cycle
// [R6] reset leaves autoselect or timeout status
// [R7] fourth autoselect cycle reads, upper byte ignored
// [R8] device identity read in three cycles
// [R9] protect verify returns zero or one
// [R10] bypass program only after bypass entry
// [R11] bypass reset command leaves bypass mode
// [R12] suspended erase allows reads, programs, autoselect
// [R13] suspend valid only during sector erase
// [R14] resume valid only while suspended
// [R15] query only in read or autoselect
// [R16] repeated resume writes are ignored
// [R17] suspended sector reads give status
// [R18] mismatched sequence returns to read mode
`timescale 1ns/1ns
`include "fcs_regs.svh"
module fcs_host
  import fcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input fcs_op_e req_op,
  input wire logic [19:0] req_addr,
  input wire logic [15:0] req_data,
  output logic req_ready_q,
  output logic rd_valid_q,
  output logic [15:0] rd_data_q,
  output logic done_q,
  output logic refused_q,
  output logic bypass_q,
  output logic erasing_q,
  output logic suspended_q,
  input wire logic [15:0] dq_in,
  output fcs_pins_s pins_q
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_RUN = 3'b010,
    HS_WAIT = 3'b100
  } fcs_hs_e;

  fcs_hs_e st_q;
  fcs_op_e op_q;
  logic [19:0] addr_q;
  logic [15:0] data_q;
  logic [2:0] step_q;
  logic sector_erase_q;
  logic resumed_q;
  logic timeout_q;
  logic tmo_now;
  logic cyc_start;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  fcs_step_s cur;
  fcs_step_s nxt;

  // unlock prefix shared by all long sequences
  function automatic fcs_step_s unlock(input logic [2:0] s,
                                       input logic [15:0] cmd);
    fcs_step_s r;
    r = '0;
    r.valid = 1'b1;
    r.wr = 1'b1;
    r.addr = (s == 3'h1) ? `FCS_A_UNLOCK2 : `FCS_A_UNLOCK1; // R4
    r.data = (s == 3'h0) ? `FCS_D_UNLOCK1 :
             (s == 3'h1) ? `FCS_D_UNLOCK2 : cmd; // R4
    return r;
  endfunction : unlock

  // write cycle helper
  function automatic fcs_step_s wcyc(input logic [19:0] a,
                                     input logic [15:0] d);
    fcs_step_s r;
    r = '0;
    r.valid = 1'b1;
    r.wr = 1'b1;
    r.addr = a;
    r.data = d;
    return r;
  endfunction : wcyc

  // read cycle helper
  function automatic fcs_step_s rcyc(input logic [19:0] a,
                                     input logic [1:0] k);
    fcs_step_s r;
    r = '0;
    r.valid = 1'b1;
    r.addr = a;
    r.rd_kind = k;
    return r;
  endfunction : rcyc

  // sequence table: bus cycle for a given operation and step
  function automatic fcs_step_s seq(input fcs_op_e op, input logic [2:0] s,
                                    input logic [19:0] a,
                                    input logic [15:0] d,
                                    input logic byp, input logic tmo);
    fcs_step_s r;
    logic [19:0] sect;
    r = '0;
    sect = a & `FCS_SECT_MASK; // R3
    case (op)
      FCS_OP_READ: if (s == 3'h0) r = rcyc(a, 2'h0); // R5
      FCS_OP_STATUS: begin
        if (s == 3'h0) r = rcyc(a, 2'h0); // R17
        else if (s == 3'h1 && tmo) r = wcyc(`FCS_A_ZERO, `FCS_D_RESET); // R6
      end
      FCS_OP_PROGRAM: begin
        if (byp) begin
          if (s == 3'h0) r = wcyc(`FCS_A_ZERO, `FCS_D_PROGRAM); // R10
          else if (s == 3'h1) r = wcyc(a, d);
        end else begin
          if (s < 3'h3) r = unlock(s, `FCS_D_PROGRAM);
          else if (s == 3'h3) r = wcyc(a, d);
        end
      end
      FCS_OP_RESET: begin
        if (byp) begin
          if (s == 3'h0) r = wcyc(`FCS_A_ZERO, `FCS_D_AUTOSEL); // R11
          else if (s == 3'h1) r = wcyc(`FCS_A_ZERO, `FCS_D_BYP_EXIT);
        end else if (s == 3'h0) begin
          r = wcyc(`FCS_A_ZERO, `FCS_D_RESET); // R6
        end
      end
      FCS_OP_MFR_ID: begin
        if (s < 3'h3) r = unlock(s, `FCS_D_AUTOSEL);
        else if (s == 3'h3) r = rcyc(`FCS_A_MFR, 2'h1); // R7
        else if (s == 3'h4) r = wcyc(`FCS_A_ZERO, `FCS_D_RESET); // R6
      end
      FCS_OP_DEV_ID: begin
        if (s < 3'h3) r = unlock(s, `FCS_D_AUTOSEL);
        else if (s == 3'h3) r = rcyc(`FCS_A_ID1, 2'h0); // R8
        else if (s == 3'h4) r = rcyc(`FCS_A_ID2, 2'h0); // R8
        else if (s == 3'h5) r = rcyc(`FCS_A_ID3, 2'h0); // R8
        else if (s == `FCS_LAST_STEP) r = wcyc(`FCS_A_ZERO, `FCS_D_RESET);
      end
      FCS_OP_PROT_VERIFY: begin
        if (s < 3'h3) r = unlock(s, `FCS_D_AUTOSEL);
        else if (s == 3'h3) r = rcyc(sect | `FCS_A_PROT, 2'h2); // R9
        else if (s == 3'h4) r = wcyc(`FCS_A_ZERO, `FCS_D_RESET); // R6
      end
      FCS_OP_BYPASS_ENTER: if (s < 3'h3) r = unlock(s, `FCS_D_BYPASS);
      FCS_OP_CHIP_ERASE, FCS_OP_SECTOR_ERASE: begin
        if (s < 3'h3) r = unlock(s, `FCS_D_ERASE);
        else if (s < 3'h5) r = unlock(s - 3'h3, `FCS_D_ERASE);
        else if (s == 3'h5) begin
          r = (op == FCS_OP_SECTOR_ERASE) ?
              wcyc(sect, `FCS_D_SECTOR) : // R3
              wcyc(`FCS_A_UNLOCK1, `FCS_D_CHIP);
        end
      end
      FCS_OP_SUSPEND: if (s == 3'h0) r = wcyc(`FCS_A_ZERO, `FCS_D_SUSPEND);
      FCS_OP_RESUME: if (s == 3'h0) r = wcyc(`FCS_A_ZERO, `FCS_D_RESUME);
      FCS_OP_QUERY: if (s == 3'h0) r = wcyc(`FCS_A_QUERY, `FCS_D_QUERY);
      default: r = '0;
    endcase
    return r;
  endfunction : seq

  // admission check against the tracked device mode
  function automatic logic allowed(input fcs_op_e op, input logic byp,
                                   input logic ers, input logic sec,
                                   input logic sus, input logic res);
    logic ok;
    ok = 1'b1;
    case (op)
      FCS_OP_SUSPEND: ok = ers && sec && !sus; // R13
      FCS_OP_RESUME: ok = sus && !res; // R14 R16
      FCS_OP_QUERY: ok = !byp && !ers; // R15
      FCS_OP_MFR_ID, FCS_OP_DEV_ID, FCS_OP_PROT_VERIFY:
        ok = !byp && (!ers || sus); // R12
      FCS_OP_CHIP_ERASE, FCS_OP_SECTOR_ERASE, FCS_OP_BYPASS_ENTER:
        ok = !ers && !byp;
      FCS_OP_PROGRAM: ok = !ers || sus; // R12
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : allowed

  // timeout from the status read finishing now, so the reset write follows
  assign tmo_now = (op_q == FCS_OP_STATUS && step_q == 3'h0) ?
                   (cyc_rdata[`FCS_BIT_TIMEOUT] &&
                    !cyc_rdata[`FCS_BIT_TOP]) : timeout_q; // R6
  assign cur = seq(op_q, step_q, addr_q, data_q, bypass_q, tmo_now);
  assign nxt = seq(op_q, step_q + 3'h1, addr_q, data_q, bypass_q,
                   tmo_now);
  assign cyc_start = (st_q == HS_RUN);

  fcs_bus_cycle u_cyc (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(cyc_start),
    .wr(cur.wr),
    .addr(cur.addr),
    .wdata(cur.data),
    .dq_in(dq_in),
    .pins_q(pins_q),
    .done_q(cyc_done),
    .rdata_q(cyc_rdata)
  );

  // request acceptance and step walking
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= HS_IDLE;
      op_q <= FCS_OP_READ;
      addr_q <= 20'h0_0000;
      data_q <= 16'h0000;
      step_q <= 3'h0;
      req_ready_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      case (st_q)
        HS_IDLE: begin
          req_ready_q <= 1'b1;
          if (req_valid && req_ready_q) begin
            req_ready_q <= 1'b0;
            if (allowed(req_op, bypass_q, erasing_q, sector_erase_q,
                        suspended_q, resumed_q)) begin
              st_q <= HS_RUN;
              op_q <= req_op;
              addr_q <= req_addr;
              data_q <= req_data;
              step_q <= 3'h0;
            end else begin
              done_q <= 1'b1;
              refused_q <= 1'b1;
            end
          end
        end
        HS_RUN: st_q <= HS_WAIT;
        HS_WAIT: begin
          if (cyc_done) begin
            step_q <= step_q + 3'h1;
            if (nxt.valid) begin
              st_q <= HS_RUN;
            end else begin
              st_q <= HS_IDLE;
              done_q <= 1'b1;
            end
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // read data returned to the user, masked per read kind
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      rd_valid_q <= 1'b0;
      if (st_q == HS_WAIT && cyc_done && !cur.wr) begin
        rd_valid_q <= 1'b1;
        case (cur.rd_kind)
          2'h1: rd_data_q <= cyc_rdata & `FCS_D_LOW_MASK; // R7
          2'h2: rd_data_q <= cyc_rdata & `FCS_D_BIT0_MASK; // R9
          default: rd_data_q <= cyc_rdata; // R5
        endcase
      end
    end
  end

  // device mode tracking, updated when a sequence finishes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_q <= 1'b0;
      erasing_q <= 1'b0;
      sector_erase_q <= 1'b0;
      suspended_q <= 1'b0;
      resumed_q <= 1'b0;
      timeout_q <= 1'b0;
    end else if (st_q == HS_WAIT && cyc_done) begin
      if (op_q == FCS_OP_STATUS && step_q == 3'h0) begin
        timeout_q <= cyc_rdata[`FCS_BIT_TIMEOUT] &&
                     !cyc_rdata[`FCS_BIT_TOP]; // R6
        if (cyc_rdata[`FCS_BIT_TOP] && !suspended_q) begin
          erasing_q <= 1'b0;
          sector_erase_q <= 1'b0;
          resumed_q <= 1'b0;
        end
      end
      if (!nxt.valid) begin
        case (op_q)
          FCS_OP_BYPASS_ENTER: bypass_q <= 1'b1; // R10
          FCS_OP_RESET: begin
            bypass_q <= 1'b0; // R11
            timeout_q <= 1'b0;
          end
          FCS_OP_STATUS: begin
            if (timeout_q) begin
              erasing_q <= 1'b0; // R6
              sector_erase_q <= 1'b0;
              suspended_q <= 1'b0;
              resumed_q <= 1'b0;
              timeout_q <= 1'b0;
            end
          end
          FCS_OP_CHIP_ERASE: erasing_q <= 1'b1;
          FCS_OP_SECTOR_ERASE: begin
            erasing_q <= 1'b1;
            sector_erase_q <= 1'b1;
            resumed_q <= 1'b0;
          end
          FCS_OP_SUSPEND: begin
            suspended_q <= 1'b1; // R13
            resumed_q <= 1'b0;
          end
          FCS_OP_RESUME: begin
            suspended_q <= 1'b0; // R14
            resumed_q <= 1'b1; // R16
          end
          default: timeout_q <= timeout_q;
        endcase
      end
    end
  end

endmodule : fcs_host

//--- inc/fcs_regs.svh
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

// clock period and bus timing, in ns
`define FCS_CLK_NS 4
`define FCS_T_SETUP_NS 10
`define FCS_T_WP_NS 35
`define FCS_T_WPH_NS 30
`define FCS_T_ACC_NS 90
// least times round up to whole clock cycles
`define FCS_CYC(ns) (((ns) + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
// cycles lost in the two-stage input synchroniser
`define FCS_SYNC_CYC 2

// unlock and command locations in low address bits only, sector mask on the high bits
`define FCS_A_UNLOCK1 20'h0_0555
`define FCS_A_UNLOCK2 20'h0_02AA
`define FCS_A_QUERY 20'h0_0055
`define FCS_A_ZERO 20'h0_0000
`define FCS_A_MFR 20'h0_0000
`define FCS_A_PROT 20'h0_0002
`define FCS_A_ID1 20'h0_0001
`define FCS_A_ID2 20'h0_0002
`define FCS_A_ID3 20'h0_0003
`define FCS_SECT_MASK 20'hF_8000

// command data, upper byte driven zero
`define FCS_D_UNLOCK1 16'h00AA
`define FCS_D_UNLOCK2 16'h0055
`define FCS_D_AUTOSEL 16'h0090
`define FCS_D_PROGRAM 16'h00A0
`define FCS_D_BYPASS 16'h0020
`define FCS_D_ERASE 16'h0080
`define FCS_D_CHIP 16'h0010
`define FCS_D_SECTOR 16'h0030
`define FCS_D_SUSPEND 16'h00B0
`define FCS_D_RESUME 16'h0030
`define FCS_D_RESET 16'h00F0
`define FCS_D_BYP_EXIT 16'h0000
`define FCS_D_QUERY 16'h0098
`define FCS_D_LOW_MASK 16'h00FF
`define FCS_D_BIT0_MASK 16'h0001

// status bit positions, and the last device identity step
`define FCS_BIT_TOP 7
`define FCS_BIT_TIMEOUT 5
`define FCS_LAST_STEP 3'h6

`endif

//--- inc/fcs_pkg.sv
package fcs_pkg;

  typedef enum logic [3:0] {
    FCS_OP_READ = 4'h0,
    FCS_OP_PROGRAM = 4'h1,
    FCS_OP_RESET = 4'h2,
    FCS_OP_MFR_ID = 4'h3,
    FCS_OP_DEV_ID = 4'h4,
    FCS_OP_PROT_VERIFY = 4'h5,
    FCS_OP_BYPASS_ENTER = 4'h6,
    FCS_OP_CHIP_ERASE = 4'h7,
    FCS_OP_SECTOR_ERASE = 4'h8,
    FCS_OP_SUSPEND = 4'h9,
    FCS_OP_RESUME = 4'hA,
    FCS_OP_QUERY = 4'hB,
    FCS_OP_STATUS = 4'hC
  } fcs_op_e;

  // flash pins as driven by the host
  typedef struct packed {
    logic ce_b;
    logic we_b;
    logic oe_b;
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } fcs_pins_s;

  // one bus cycle of a command sequence
  typedef struct packed {
    logic valid;
    logic wr;
    logic [19:0] addr;
    logic [15:0] data;
    logic [1:0] rd_kind; // 0 array, 1 low byte, 2 bit0
  } fcs_step_s;

endpackage : fcs_pkg

//--- core/fcs_bus_cycle.sv
`timescale 1ns/1ns
`include "fcs_regs.svh"
module fcs_bus_cycle
  import fcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic wr,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output fcs_pins_s pins_q,
  output logic done_q,
  output logic [15:0] rdata_q
);

  localparam logic [7:0] SETUP_C = 8'(`FCS_CYC(`FCS_T_SETUP_NS));
  localparam logic [7:0] WP_C = 8'(`FCS_CYC(`FCS_T_WP_NS));
  localparam logic [7:0] WPH_C = 8'(`FCS_CYC(`FCS_T_WPH_NS));
  localparam logic [7:0] ACC_C =
    8'(`FCS_CYC(`FCS_T_ACC_NS) + `FCS_SYNC_CYC);

  typedef enum logic [3:0] {
    BC_IDLE = 4'b0001,
    BC_SETUP = 4'b0010,
    BC_PULSE = 4'b0100,
    BC_HOLD = 4'b1000
  } fcs_bc_e;

  fcs_bc_e st_q;
  logic [7:0] cnt_q;
  logic wr_q;
  logic [15:0] dq_s1_q;
  logic [15:0] dq_s2_q;

  // two-stage synchroniser on the data pins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // cycle sequencer: setup, strobe pulse, hold
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= BC_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        BC_IDLE: begin
          if (start) begin
            st_q <= BC_SETUP;
            cnt_q <= SETUP_C;
            wr_q <= wr;
          end
        end
        BC_SETUP: begin
          if (cnt_q <= 8'h01) begin
            st_q <= BC_PULSE;
            cnt_q <= wr_q ? WP_C : ACC_C;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        BC_PULSE: begin
          if (cnt_q <= 8'h01) begin
            st_q <= BC_HOLD;
            cnt_q <= WPH_C;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        BC_HOLD: begin
          if (cnt_q <= 8'h01) begin
            st_q <= BC_IDLE;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: st_q <= BC_IDLE;
      endcase
    end
  end

  // pin drive; address and data settle before the strobe falls
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pins_q <= '{ce_b: 1'b1, we_b: 1'b1, oe_b: 1'b1, addr: 20'h0_0000,
                  dq_out: 16'h0000, dq_oe: 1'b0};
    end else begin
      if (st_q == BC_IDLE && start) begin
        pins_q.addr <= addr; // R1
        pins_q.dq_out <= wdata; // R2
        pins_q.dq_oe <= wr;
        pins_q.ce_b <= 1'b0;
      end
      if (st_q == BC_SETUP && cnt_q <= 8'h01) begin
        pins_q.we_b <= !wr_q; // R1
        pins_q.oe_b <= wr_q;
      end
      if (st_q == BC_PULSE && cnt_q <= 8'h01) begin
        pins_q.we_b <= 1'b1; // R2
        pins_q.oe_b <= 1'b1;
        pins_q.ce_b <= 1'b1;
      end
      if (st_q == BC_HOLD && cnt_q <= 8'h01) begin
        pins_q.dq_oe <= 1'b0; // data held past the rising strobe
      end
    end
  end

  // read data captured at the end of the access window
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else if (st_q == BC_PULSE && cnt_q <= 8'h01 && !wr_q) begin
      rdata_q <= dq_s2_q;
    end
  end

endmodule : fcs_bus_cycle

//--- verif/fcs_flash_model.sv
`timescale 1ns/1ns
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [15:0] MFR_WORD = 16'hc33c, // arbitrary value
  parameter logic [15:0] ID1_WORD = 16'h7e11, // arbitrary value
  parameter logic [15:0] ID2_WORD = 16'h2250, // arbitrary value
  parameter logic [15:0] ID3_WORD = 16'h2262, // arbitrary value
  parameter logic [4:0] PROT_SECT = 5'h03
)(
  input fcs_pins_s pins,
  input wire logic tmo,
  output logic [15:0] dq
);
  logic [15:0] mem [0:255];
  logic [19:0] a_q = '0;
  logic [15:0] last_q = '0;
  logic [2:0] step_q = '0;
  logic [4:0] sect_q = '0;
  logic open_q = 0, asel_q = 0, byp_q = 0, bx_q = 0, prg_q = 0;
  logic ers_q = 0, chip_q = 0, sus_q = 0, qry_q = 0;

  // blank array, aliased by low address byte
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
  end

  // command decode; upper address and data bits ignored
  task automatic decode(input logic [19:0] a, input logic [15:0] d);
    logic [7:0] c;
    logic u1, u2;
    c = d[7:0];
    u1 = a[11:0] == 12'h555;
    u2 = a[11:0] == 12'h2aa;
    if (prg_q) begin
      mem[a[7:0]] = mem[a[7:0]] & d;
      prg_q = 0;
    end else if (byp_q) begin
      if (bx_q && c == 8'h00) byp_q = 0;
      prg_q = c == 8'ha0;
      bx_q = c == 8'h90;
    end else if (step_q == 0 && c == 8'hf0) begin
      if (ers_q && tmo) ers_q = 0;
      asel_q = 0;
      qry_q = 0;
    end else if (step_q == 0 && c == 8'hb0) begin
      sus_q = sus_q | (ers_q & !chip_q);
    end else if (step_q == 0 && c == 8'h30) begin
      sus_q = 0;
    end else if (step_q == 0 && c == 8'h98 && a[7:0] == 8'h55) begin
      qry_q = !ers_q || asel_q;
    end else begin
      case (step_q)
        3'h0, 3'h3: step_q = (u1 && c == 8'haa) ? step_q + 1 : 0;
        3'h1, 3'h4: step_q = (u2 && c == 8'h55) ? step_q + 1 : 0;
        3'h2: begin
          step_q = 0;
          if (u1 && c == 8'h90) asel_q = 1;
          if (u1 && c == 8'ha0) prg_q = 1;
          if (u1 && c == 8'h20) byp_q = 1;
          if (u1 && c == 8'h80) step_q = 3;
        end
        default: begin
          step_q = 0;
          if (u1 && c == 8'h10) {ers_q, chip_q} = 2'b11;
          if (c == 8'h30) {ers_q, chip_q, sect_q} = {2'b10, a[19:15]};
        end
      endcase
    end
  endtask : decode

  // address at the later falling strobe
  always @(negedge pins.we_b or negedge pins.ce_b) begin
    if (!pins.we_b && !pins.ce_b) begin
      a_q = pins.addr;
      open_q = 1;
    end
  end

  // data at the earlier rising strobe
  always @(posedge pins.we_b or posedge pins.ce_b) begin
    if (open_q) begin
      open_q = 0;
      decode(a_q, pins.dq_out);
    end
  end

  // read data; released bus shows inverse of last word
  always @(pins.oe_b, pins.ce_b, pins.addr, tmo) begin
    if (!pins.ce_b && !pins.oe_b) begin
      if (asel_q) begin
        case (pins.addr[1:0])
          2'h0: dq = MFR_WORD;
          2'h1: dq = ID1_WORD;
          2'h2: dq = ID2_WORD |
                     {15'h0000, pins.addr[19:15] == PROT_SECT};
          default: dq = ID3_WORD;
        endcase
      end else if (qry_q) begin
        dq = 16'h0051;
      end else if (ers_q && (!sus_q || pins.addr[19:15] == sect_q)) begin
        dq = {10'h000, tmo, 5'h00};
      end else begin
        dq = mem[pins.addr[7:0]];
      end
      last_q = dq;
    end else begin
      dq = ~last_q;
    end
  end
endmodule : fcs_flash_model

//--- verif/fcs_host_checker.sv
`timescale 1ns/1ns
module fcs_host_checker
  import fcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input fcs_op_e req_op,
  input wire logic req_ready_q,
  input wire logic rd_valid_q,
  input wire logic [15:0] rd_data_q,
  input wire logic done_q,
  input wire logic refused_q,
  input wire logic bypass_q,
  input wire logic erasing_q,
  input wire logic suspended_q,
  input fcs_pins_s pins_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // request taken with given operation
  sequence take_s(fcs_op_e op);
    req_valid && req_ready_q && req_op == op;
  endsequence
  sequence wr_low_s;
    !pins_q.we_b && !pins_q.ce_b;
  endsequence
  sequence refuse_s;
    done_q && refused_q;
  endsequence

  susp_refuse_a: assert property (
    take_s(FCS_OP_SUSPEND) ##0 !erasing_q |=> refuse_s)
    else $error("suspend taken while idle");
  resume_refuse_a: assert property (
    take_s(FCS_OP_RESUME) ##0 !suspended_q |=> refuse_s)
    else $error("resume taken while not suspended");
  query_refuse_a: assert property (
    take_s(FCS_OP_QUERY) ##0 (bypass_q || erasing_q) |=> refuse_s)
    else $error("query taken in wrong mode");
  bypass_prog_a: assert property (
    take_s(FCS_OP_PROGRAM) ##0 bypass_q |=> !refused_q)
    else $error("bypass program refused");
  bypass_exit_a: assert property (
    take_s(FCS_OP_RESET) ##0 bypass_q |-> ##[1:300] (done_q && !bypass_q))
    else $error("bypass mode not left");
  addr_setup_a: assert property (
    $fell(pins_q.we_b) |-> !pins_q.ce_b && $past(pins_q.ce_b, 2) == 1'b0
      && $stable(pins_q.addr))
    else $error("address not set up before strobe");
  data_hold_a: assert property (
    $rose(pins_q.we_b) |-> (pins_q.dq_oe && $stable(pins_q.dq_out)
      && $stable(pins_q.addr)) [*7])
    else $error("write data not held");
  pulse_width_a: assert property (
    $fell(pins_q.we_b) |-> wr_low_s [*8])
    else $error("write pulse too short");
  read_cycle_a: assert property (
    $fell(pins_q.oe_b) |-> (!pins_q.ce_b && pins_q.we_b && !pins_q.dq_oe) [*8])
    else $error("read cycle disturbed");
  mfr_byte_a: assert property (
    take_s(FCS_OP_MFR_ID) ##1 !refused_q |-> ##[0:400]
      (rd_valid_q && rd_data_q[15:8] == 8'h00))
    else $error("identity upper byte not masked");
  prot_bit_a: assert property (
    take_s(FCS_OP_PROT_VERIFY) ##1 !refused_q |-> ##[0:400] (rd_valid_q
      && rd_data_q[15:1] == 15'h0000))
    else $error("protect verify not zero or one");
endmodule : fcs_host_checker

//--- verif/fcs_host_test.sv
`timescale 1ns/1ns
module fcs_host_test
  import fcs_pkg::*;
;
  logic mclk, rst_b, req_valid, tmo;
  fcs_op_e req_op;
  logic [19:0] req_addr;
  logic [15:0] req_data, rd_data_q, dq_in;
  logic req_ready_q, rd_valid_q, done_q, refused_q;
  logic bypass_q, erasing_q, suspended_q;
  fcs_pins_s pins_q;
  int failures = 0;
  int n_compared = 0;
  logic [15:0] rd_q [$];

  fcs_host i_fcs_host (.mclk, .rst_b, .req_valid, .req_op, .req_addr,
    .req_data, .req_ready_q, .rd_valid_q, .rd_data_q, .done_q, .refused_q,
    .bypass_q, .erasing_q, .suspended_q, .dq_in, .pins_q);
  fcs_flash_model i_fcs_flash_model (.pins(pins_q), .tmo(tmo), .dq(dq_in));

  // 250 MHz clock
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one request, words collected until done
  task automatic run(input fcs_op_e op, input logic [19:0] a,
    input logic [15:0] d, input logic ref_exp);
    int n;
    rd_q.delete();
    @(negedge mclk);
    req_valid = 1;
    req_op = op;
    req_addr = a;
    req_data = d;
    n = 0;
    // ready seen at a falling edge: the next rising edge takes the request
    while (req_ready_q !== 1'b1 && n < 99) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    req_valid = 0;
    n = 0;
    // a refusal answers right after the taking edge, so look before waiting
    do begin
      if (rd_valid_q === 1'b1) rd_q.push_back(rd_data_q);
      if (done_q === 1'b1) break;
      @(negedge mclk);
      n++;
    end while (n < 3000);
    chk("done seen", 16'h0001, {15'h0000, done_q});
    chk("refused", {15'h0000, ref_exp}, {15'h0000, refused_q});
  endtask : run

  task automatic t_prog_read;
    run(FCS_OP_PROGRAM, 20'h0_1234, 16'h5a3c, 0);
    run(FCS_OP_READ, 20'h0_1234, 16'h0000, 0);
    chk("read count", 16'h0001, 16'(rd_q.size()));
    chk("array word", 16'h5a3c, rd_q[0]);
  endtask : t_prog_read

  task automatic t_ident;
    run(FCS_OP_MFR_ID, 20'h0_0000, 16'h0000, 0);
    chk("maker word", 16'h003c, rd_q[0]);
    run(FCS_OP_DEV_ID, 20'h0_0000, 16'h0000, 0);
    chk("id count", 16'h0003, 16'(rd_q.size()));
    chk("id word 1", 16'h7e11, rd_q[0]);
    chk("id word 2", 16'h2250, rd_q[1]);
    chk("id word 3", 16'h2262, rd_q[2]);
    run(FCS_OP_PROT_VERIFY, 20'h1_8002, 16'h0000, 0);
    chk("protected", 16'h0001, rd_q[0]);
    run(FCS_OP_PROT_VERIFY, 20'h0_8002, 16'h0000, 0);
    chk("unprotected", 16'h0000, rd_q[0]);
    run(FCS_OP_READ, 20'h0_1234, 16'h0000, 0);
    chk("back to array", 16'h5a3c, rd_q[0]);
  endtask : t_ident

  task automatic t_bypass;
    run(FCS_OP_BYPASS_ENTER, 20'h0_0000, 16'h0000, 0);
    chk("bypass on", 16'h0001, {15'h0000, bypass_q});
    run(FCS_OP_PROGRAM, 20'h0_1256, 16'h0f0f, 0);
    run(FCS_OP_QUERY, 20'h0_0055, 16'h0000, 1);
    run(FCS_OP_RESET, 20'h0_0000, 16'h0000, 0);
    chk("bypass off", 16'h0000, {15'h0000, bypass_q});
    chk("model bypass", 16'h0000, {15'h0000, i_fcs_flash_model.byp_q});
    run(FCS_OP_READ, 20'h0_1256, 16'h0000, 0);
    chk("bypass word", 16'h0f0f, rd_q[0]);
    run(FCS_OP_QUERY, 20'h0_0055, 16'h0000, 0);
    run(FCS_OP_READ, 20'h0_0010, 16'h0000, 0);
    chk("query word", 16'h0051, rd_q[0]);
    run(FCS_OP_RESET, 20'h0_0000, 16'h0000, 0);
  endtask : t_bypass

  task automatic t_erase;
    run(FCS_OP_SUSPEND, 20'h0_0000, 16'h0000, 1);
    run(FCS_OP_CHIP_ERASE, 20'h0_0000, 16'h0000, 0);
    run(FCS_OP_SUSPEND, 20'h0_0000, 16'h0000, 1);
    tmo = 1;
    run(FCS_OP_STATUS, 20'h0_0000, 16'h0000, 0);
    chk("timeout word", 16'h0020, rd_q[0]);
    chk("erase cleared", 16'h0000, {15'h0000, erasing_q});
    chk("model erase", 16'h0000, {15'h0000, i_fcs_flash_model.ers_q});
    tmo = 0;
    run(FCS_OP_SECTOR_ERASE, 20'h2_0000, 16'h0000, 0);
    run(FCS_OP_RESUME, 20'h0_0000, 16'h0000, 1);
    run(FCS_OP_SUSPEND, 20'h0_0000, 16'h0000, 0);
    chk("suspended", 16'h0001, {15'h0000, suspended_q});
    run(FCS_OP_READ, 20'h2_0040, 16'h0000, 0);
    chk("status word", 16'h0000, rd_q[0]);
    run(FCS_OP_PROGRAM, 20'h4_0010, 16'h1234, 0);
    run(FCS_OP_READ, 20'h4_0010, 16'h0000, 0);
    chk("other sector", 16'h1234, rd_q[0]);
    run(FCS_OP_MFR_ID, 20'h0_0000, 16'h0000, 0);
    chk("maker in suspend", 16'h003c, rd_q[0]);
    run(FCS_OP_RESUME, 20'h0_0000, 16'h0000, 0);
    chk("resumed", 16'h0000, {15'h0000, suspended_q});
    run(FCS_OP_RESUME, 20'h0_0000, 16'h0000, 1);
    tmo = 1;
    run(FCS_OP_STATUS, 20'h2_0000, 16'h0000, 0);
    chk("erase ended", 16'h0000, {15'h0000, erasing_q});
    tmo = 0;
  endtask : t_erase

  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    rst_b = 0;
    req_valid = 0;
    req_op = FCS_OP_READ;
    req_addr = '0;
    req_data = '0;
    tmo = 0;
    repeat (5) @(negedge mclk);
    rst_b = 1;
    t_prog_read();
    t_ident();
    t_bypass();
    t_erase();
    tally_and_finish();
  end

  // watchdog, about twenty-five times the expected run
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule : fcs_host_test

bind fcs_host fcs_host_checker i_fcs_host_checker (.mclk, .rst_b, .req_valid,
  .req_op, .req_ready_q, .rd_valid_q, .rd_data_q, .done_q, .refused_q,
  .bypass_q, .erasing_q, .suspended_q, .pins_q);
